/* File: hdl/i2c_status_flag_logic.sv */
// status and bus flag logic of the on-chip i2c interface
//
// Contract
// (RQ1) master flag: set on start, cleared on loss
// (RQ2) arbitration loss sets flag, clears on read
// (RQ3) bit-manipulation on status also clears loss flag
// (RQ4) extension code flag at eighth clock rise
// (RQ5) address match flag at eighth clock rise
// (RQ6) transmit flag drives data from ninth fall
// (RQ7) transmit flag set by start or direction
// (RQ8) transmit flag cleared by stop, exit, direction
// (RQ9) wait release in transmit floats data line
// (RQ10) ack flag set on low ninth clock
// (RQ11) start flag marks the address transfer period
// (RQ12) stop flag cleared at next address byte
// (RQ13) fail and busy read-only, options write disabled
// (RQ14) failed start clears trigger, sets fail flag
// (RQ15) busy set on start, cleared on stop
// (RQ16) initial start option skips first stop wait
// (RQ17) flag register resets zero, bits 5..2 zero
// (RQ18) start and stop sampled on link clock
`include "i2c_flag_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module i2c_status_flag_logic
  import i2c_flag_pkg::*;
(
  // cpu clock and reset
  input  wire logic  CLK,
  input  wire logic  RST,
  // internal register bus
  input  wire addr_t ADDR,
  input  wire reg8_t WDATA,
  input  wire logic  WR,
  input  wire logic  RD,
  input  wire logic  BITOP,
  output logic       [7:0] RDATA,
  // control bits from the control registers, cpu domain
  input  wire logic  INTERFACE_ENABLE,
  input  wire logic  WAKEUP_ENABLE,
  input  wire logic  COMMUNICATION_EXIT,
  input  wire logic  WAIT_RELEASE,
  input  wire logic  START_TRIGGER_SET,
  input  wire addr7_t LOCAL_SLAVE_ADDRESS,
  output logic       START_TRIGGER_CLEAR,
  // link side, interface operating clock
  input  wire logic  LCLK,
  input  wire logic  START_GENERATED,
  input  wire logic  ARBITRATION_LOST,
  input  wire logic  TRANSMIT_DATA_LATCH,
  // bus pins, open drain
  input  wire logic  SERIAL_CLOCK_LINE_IN,
  input  wire logic  SERIAL_DATA_LINE_IN,
  output logic       SERIAL_DATA_LINE_OUT,
  output logic       SERIAL_DATA_LINE_OE_N
);

  // ---------------- link domain: synchronisers ----------------
  logic [1:0] lrst_q;        // reset carried into the link domain
  // cpu side toggles and option bit, declared here as the link reads them
  logic       exit_tg_q, wrel_tg_q, aclr_tg_q;
  logic       ist_bit_q;
  logic [2:0] scl_q, sda_q;  // two sync stages plus one history stage
  logic [1:0] en_q, wup_q, ist_q; // level crossings
  logic       en_prev_q, wup_prev_q;
  logic [1:0] adr_q [7];     // slave address crossing, quasi static
  logic [2:0] exit_q, wrel_q, aclr_q; // toggle event crossings
  logic       lrst;
  addr7_t     local_adr;

  // every crossing is a two-flop chain; the edge and toggle detectors also read a third history stage
  always_ff @(posedge LCLK)
  begin
    lrst_q     <= {lrst_q[0], RST};
    scl_q      <= {scl_q[1:0], SERIAL_CLOCK_LINE_IN};
    sda_q      <= {sda_q[1:0], SERIAL_DATA_LINE_IN};
    en_q       <= {en_q[0], INTERFACE_ENABLE};
    wup_q      <= {wup_q[0], WAKEUP_ENABLE};
    ist_q      <= {ist_q[0], ist_bit_q};
    en_prev_q  <= en_q[1];
    wup_prev_q <= wup_q[1];
    exit_q     <= {exit_q[1:0], exit_tg_q};
    wrel_q     <= {wrel_q[1:0], wrel_tg_q};
    aclr_q     <= {aclr_q[1:0], aclr_tg_q};
    for (int i = 0; i < 7; i++)
    begin
      adr_q[i] <= {adr_q[i][0], LOCAL_SLAVE_ADDRESS[i]};
    end
  end

  assign lrst = lrst_q[1];
  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      local_adr[i] = adr_q[i][1];
    end
  end

  // ---------------- link domain: bus events ----------------
  logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
  logic dis, en_rise, wup_fall, exit_p, wrel_p, aclr_p;
  assign scl       = scl_q[1];
  assign sda       = sda_q[1];
  assign scl_rise  = scl & ~scl_q[2];
  assign scl_fall  = ~scl & scl_q[2];
  // start: data falls while clock stays high; stop: data rises
  assign start_det = scl & scl_q[2] & ~sda & sda_q[2]; // see (RQ18)
  assign stop_det  = scl & scl_q[2] & sda & ~sda_q[2]; // see (RQ18)
  assign dis       = ~en_q[1];   // disable clears every flag each cycle; a same-cycle set still wins
  assign en_rise   = en_q[1] & ~en_prev_q;
  assign wup_fall  = wup_prev_q & ~wup_q[1];
  assign exit_p    = exit_q[2] ^ exit_q[1];
  assign wrel_p    = wrel_q[2] ^ wrel_q[1];
  assign aclr_p    = aclr_q[2] ^ aclr_q[1];

  // ---------------- link domain: byte tracking ----------------
  bitcnt_t cnt_q, cnt_d;     // clock count within current byte
  reg8_t   sh_q, sh_d;       // received bits
  logic    aph_q, aph_d;     // inside the address byte
  logic    txw_q, txw_d;     // data output window opened
  logic    addr8, ack9, first_clk;

  assign addr8     = scl_rise & aph_q & (cnt_q == `BIT_COUNT_ADDR8 - 4'h1);
  assign ack9      = scl_rise & (cnt_q == `BIT_COUNT_ACK9 - 4'h1);
  assign first_clk = scl_rise &
                     (cnt_q == `BIT_COUNT_ACK9 || cnt_q == `BIT_COUNT_IDLE);

  // next count, shift and address phase
  always_comb
  begin
    cnt_d = cnt_q;
    sh_d  = sh_q;
    aph_d = aph_q;
    txw_d = txw_q;
    if (scl_rise)
    begin
      cnt_d = (cnt_q == `BIT_COUNT_ACK9) ? 4'h1 : cnt_q + 4'h1;
      sh_d  = {sh_q[6:0], sda};
    end
    if (first_clk && cnt_q == `BIT_COUNT_ACK9)
    begin
      aph_d = 1'b0;          // address byte over
    end
    // data output opens at the first byte's ninth falling edge
    if (scl_fall && aph_q && cnt_q == `BIT_COUNT_ACK9)
    begin
      txw_d = 1'b1;          // see (RQ6)
    end
    if (start_det)
    begin
      cnt_d = `BIT_COUNT_IDLE;
      aph_d = 1'b1;
      txw_d = 1'b0;
    end
    if (stop_det || dis)
    begin
      cnt_d = `BIT_COUNT_IDLE;
      aph_d = 1'b0;
      txw_d = 1'b0;
    end
  end

  always_ff @(posedge LCLK)
  begin
    if (lrst)
    begin
      cnt_q <= `BIT_COUNT_IDLE;
      sh_q  <= `REG_RESET_VALUE;
      aph_q <= 1'b0;
      txw_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      aph_q <= aph_d;
      txw_q <= txw_d;
    end
  end

  // ---------------- link domain: status flags ----------------
  reg8_t st_q, st_d;          // status register contents
  logic  busy_q, busy_d;      // bus busy flag
  logic  stt_tg_q, stt_tg_d;  // start seen, toggled for the cpu side
  logic  ext_hit, adr_hit, addressed, dir;
  logic  oe_n_q, oe_n_d;

  assign ext_hit   = sh_q[6:3] == `EXT_CODE_LOW ||
                     sh_q[6:3] == `EXT_CODE_HIGH;
  assign adr_hit   = sh_q[6:0] == local_adr;
  assign addressed = ext_hit | adr_hit;
  assign dir       = sda;     // direction bit at the eighth rise

  // clears are applied first so that a same-cycle set wins
  always_comb
  begin
    st_d     = st_q;
    busy_d   = busy_q;
    stt_tg_d = stt_tg_q ^ start_det;
    if (stop_det || ARBITRATION_LOST || exit_p || dis)
    begin
      st_d[`ST_MASTER_BIT] = 1'b0;                 // see (RQ1) (RQ2)
    end
    if (START_GENERATED)
    begin
      st_d[`ST_MASTER_BIT] = 1'b1;                 // see (RQ1)
    end
    if (aclr_p || dis)
    begin
      st_d[`ST_ARB_LOST_BIT] = 1'b0;               // see (RQ2) (RQ3)
    end
    if (ARBITRATION_LOST)
    begin
      st_d[`ST_ARB_LOST_BIT] = 1'b1;               // see (RQ2)
    end
    if (start_det || stop_det || exit_p || dis)
    begin
      st_d[`ST_EXT_CODE_BIT]   = 1'b0;             // see (RQ4)
      st_d[`ST_ADDR_MATCH_BIT] = 1'b0;             // see (RQ5)
    end
    if (addr8 && ext_hit)
    begin
      st_d[`ST_EXT_CODE_BIT] = 1'b1;               // see (RQ4)
    end
    if (addr8 && adr_hit)
    begin
      st_d[`ST_ADDR_MATCH_BIT] = 1'b1;             // see (RQ5)
    end
    // transmit flag: clears of both roles, then sets
    if (stop_det || exit_p || dis || wrel_p || ARBITRATION_LOST ||
        (start_det && !st_q[`ST_MASTER_BIT]) ||
        (addr8 && st_q[`ST_MASTER_BIT] && dir) ||
        (addr8 && !st_q[`ST_MASTER_BIT] && (!dir || !addressed)))
    begin
      st_d[`ST_TRANSMIT_BIT] = 1'b0;               // see (RQ8) (RQ9)
    end
    if (START_GENERATED ||
        (addr8 && st_q[`ST_MASTER_BIT] && !dir) ||
        (addr8 && !st_q[`ST_MASTER_BIT] && dir && addressed))
    begin
      st_d[`ST_TRANSMIT_BIT] = 1'b1;               // see (RQ7)
    end
    if (stop_det || first_clk || exit_p || dis)
    begin
      st_d[`ST_ACK_BIT] = 1'b0;                    // see (RQ10)
    end
    if (ack9 && !sda)
    begin
      st_d[`ST_ACK_BIT] = 1'b1;                    // see (RQ10)
    end
    if (stop_det || exit_p || dis ||
        (first_clk && aph_q && cnt_q == `BIT_COUNT_ACK9))
    begin
      st_d[`ST_START_BIT] = 1'b0;                  // see (RQ11)
    end
    if (start_det)
    begin
      st_d[`ST_START_BIT] = 1'b1;                  // see (RQ11)
    end
    // stop flag survives until the next address byte begins, wakeup enable falls or the interface is disabled
    if (wup_fall || dis ||
        (first_clk && aph_q && cnt_q == `BIT_COUNT_IDLE))
    begin
      st_d[`ST_STOP_BIT] = 1'b0;                   // see (RQ12)
    end
    if (stop_det)
    begin
      st_d[`ST_STOP_BIT] = 1'b1;                   // see (RQ12)
    end
    if (stop_det || dis)
    begin
      busy_d = 1'b0;                               // see (RQ15)
    end
    // with the initial start option off, the bus counts as busy
    // until a stop is seen after enable
    if (start_det || (en_rise && !ist_q[1]))
    begin
      busy_d = 1'b1;                               // see (RQ15) (RQ16)
    end
    // open drain: pull low only for a zero while transmitting
    oe_n_d = ~(st_d[`ST_TRANSMIT_BIT] & txw_d & ~TRANSMIT_DATA_LATCH);
  end

  always_ff @(posedge LCLK)
  begin
    if (lrst)
    begin
      st_q     <= `REG_RESET_VALUE;
      busy_q   <= 1'b0;
      stt_tg_q <= 1'b0;
      oe_n_q   <= 1'b1;
    end
    else
    begin
      st_q     <= st_d;
      busy_q   <= busy_d;
      stt_tg_q <= stt_tg_d;
      oe_n_q   <= oe_n_d;                          // see (RQ6) (RQ9)
    end
  end

  assign SERIAL_DATA_LINE_OUT  = 1'b0;
  assign SERIAL_DATA_LINE_OE_N = oe_n_q;

  // ---------------- cpu domain ----------------
  logic [1:0] st_s [8];       // status bits carried back, per bit
  logic [1:0] busy_s;
  logic [2:0] stt_s;          // start toggle, two stages plus history
  reg8_t      status;
  logic       exit_tg_d, wrel_tg_d, aclr_tg_d;
  logic       stcf_q, stcf_d, ist_bit_d, rsv_q, rsv_d;
  logic       clr_q, clr_d;
  reg8_t      rdata_q, rdata_d;
  logic       start_seen, fail, st_sel, fl_sel;

  // each bit crosses alone; bits may land a cycle apart
  always_ff @(posedge CLK)
  begin
    for (int i = 0; i < 8; i++)
    begin
      st_s[i] <= {st_s[i][0], st_q[i]};
    end
    busy_s <= {busy_s[0], busy_q};
    stt_s  <= {stt_s[1:0], stt_tg_q};
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      status[i] = st_s[i][1];
    end
  end

  assign start_seen = stt_s[2] ^ stt_s[1];
  assign st_sel     = ADDR == `STATUS_REG_ADDR;
  assign fl_sel     = ADDR == `FLAG_REG_ADDR;
  // refused start: bus busy while reservation is switched off
  assign fail       = START_TRIGGER_SET & busy_s[1] & rsv_q; // see (RQ14)

  // next register values and read data
  always_comb
  begin
    exit_tg_d = exit_tg_q ^ COMMUNICATION_EXIT;
    wrel_tg_d = wrel_tg_q ^ WAIT_RELEASE;
    // any read or bit operation on status clears arbitration loss
    aclr_tg_d = aclr_tg_q ^ (st_sel & (RD | BITOP)); // see (RQ2) (RQ3)
    stcf_d    = stcf_q;
    ist_bit_d = ist_bit_q;
    rsv_d     = rsv_q;
    clr_d     = fail;                              // see (RQ14)
    if (START_TRIGGER_SET || !INTERFACE_ENABLE)
    begin
      stcf_d = 1'b0;                               // see (RQ14)
    end
    if (fail)
    begin
      stcf_d = 1'b1;                               // see (RQ14)
    end
    // option bits only take writes while the interface is off
    if (WR && fl_sel && !INTERFACE_ENABLE)
    begin
      ist_bit_d = WDATA[`FL_INIT_START_BIT];       // see (RQ13)
      rsv_d     = WDATA[`FL_RSV_DIS_BIT];          // see (RQ13)
    end
    if (start_seen)
    begin
      ist_bit_d = 1'b0;                            // see (RQ16)
    end
    rdata_d = `REG_RESET_VALUE;                    // unmapped reads zero
    if (RD && st_sel)
    begin
      rdata_d = status;
    end
    else if (RD && fl_sel)
    begin
      rdata_d[`FL_START_FAIL_BIT] = stcf_q;        // see (RQ13) (RQ17)
      rdata_d[`FL_BUS_BUSY_BIT]   = busy_s[1];
      rdata_d[`FL_INIT_START_BIT] = ist_bit_q;
      rdata_d[`FL_RSV_DIS_BIT]    = rsv_q;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      exit_tg_q <= 1'b0;
      wrel_tg_q <= 1'b0;
      aclr_tg_q <= 1'b0;
      stcf_q    <= 1'b0;                           // see (RQ17)
      ist_bit_q <= 1'b0;
      rsv_q     <= 1'b0;
      clr_q     <= 1'b0;
      rdata_q   <= `REG_RESET_VALUE;
    end
    else
    begin
      exit_tg_q <= exit_tg_d;
      wrel_tg_q <= wrel_tg_d;
      aclr_tg_q <= aclr_tg_d;
      stcf_q    <= stcf_d;
      ist_bit_q <= ist_bit_d;
      rsv_q     <= rsv_d;
      clr_q     <= clr_d;
      rdata_q   <= rdata_d;
    end
  end

  assign RDATA               = rdata_q;
  assign START_TRIGGER_CLEAR = clr_q;

endmodule : i2c_status_flag_logic

`default_nettype wire

/* File: hdl/i2c_flag_regs.svh */
// register offsets, field positions and constants of the i2c flag logic
`ifndef I2C_FLAG_REGS_SVH
`define I2C_FLAG_REGS_SVH

// register addresses on the internal bus
`define STATUS_REG_ADDR   20'hFFF51
`define FLAG_REG_ADDR     20'hFFF52
`define REG_RESET_VALUE   8'h00

// status register field positions
`define ST_MASTER_BIT     7
`define ST_ARB_LOST_BIT   6
`define ST_EXT_CODE_BIT   5
`define ST_ADDR_MATCH_BIT 4
`define ST_TRANSMIT_BIT   3
`define ST_ACK_BIT        2
`define ST_START_BIT      1
`define ST_STOP_BIT       0

// flag register field positions
`define FL_START_FAIL_BIT 7
`define FL_BUS_BUSY_BIT   6
`define FL_INIT_START_BIT 1
`define FL_RSV_DIS_BIT    0

// extension code prefixes and clock counts within a byte
`define EXT_CODE_LOW      4'h0
`define EXT_CODE_HIGH     4'hF
`define BIT_COUNT_ADDR8   4'h8
`define BIT_COUNT_ACK9    4'h9
`define BIT_COUNT_IDLE    4'h0

`endif

/* File: hdl/i2c_flag_pkg.sv */
// types shared by the i2c status and bus flag logic
package i2c_flag_pkg;
  typedef logic [7:0]  reg8_t;   // one 8-bit register
  typedef logic [3:0]  bitcnt_t; // clock count within a byte
  typedef logic [6:0]  addr7_t;  // 7-bit slave address
  typedef logic [19:0] addr_t;   // internal bus address
endpackage : i2c_flag_pkg

/* File: dv/i2c_status_flag_logic_assertions.sv */
// concurrent checks on the ports of the i2c status and flag logic
`timescale 1ns/1ps
`default_nettype none
`include "i2c_flag_regs.svh"
module i2c_status_flag_logic_assertions
  import i2c_flag_pkg::*;
(
  // clocks and reset
  input wire logic       CLK,
  input wire logic       LCLK,
  input wire logic       RST,
  // register bus
  input wire addr_t      ADDR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // controls and outputs
  input wire logic       INTERFACE_ENABLE,
  input wire logic       START_TRIGGER_SET,
  input wire logic       START_TRIGGER_CLEAR,
  input wire logic       SERIAL_DATA_LINE_OUT,
  input wire logic       SERIAL_DATA_LINE_OE_N
);
  logic [3:0] off_q; // cycles spent disabled, saturating
  logic [3:0] off_d; // next count
  // the flags clear only after the disable crosses domains, so wait for it
  always_comb
  begin
    off_d = off_q;
    if (INTERFACE_ENABLE)
      off_d = 4'h0;
    else if (off_q != 4'hF)
      off_d = off_q + 4'h1;
  end
  // register the count
  always_ff @(posedge CLK)
  begin
    if (RST)
      off_q <= 4'h0;
    else
      off_q <= off_d;
  end
  rst_zero_a:
  assert property (@(posedge CLK) disable iff (RST)
    $fell(RST) |-> RDATA == 8'h00) else $error("read data not zero");
  pad_bits_a:
  assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == `FLAG_REG_ADDR |=> RDATA[5:2] == 4'h0)
    else $error("flag pad bits not zero");
  unmapped_zero_a:
  assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR != `FLAG_REG_ADDR && ADDR != `STATUS_REG_ADDR
    |=> RDATA == 8'h00) else $error("unmapped read not zero");
  clear_cause_a:
  assert property (@(posedge CLK) disable iff (RST)
    START_TRIGGER_CLEAR |-> $past(START_TRIGGER_SET))
    else $error("trigger clear without set");
  clear_pulse_a:
  assert property (@(posedge CLK) disable iff (RST)
    START_TRIGGER_CLEAR |=> !START_TRIGGER_CLEAR)
    else $error("trigger clear longer than one cycle");
  out_low_a:
  assert property (@(posedge CLK) disable iff (RST)
    SERIAL_DATA_LINE_OUT == 1'b0) else $error("data output not low");
  float_off_a:
  assert property (@(posedge LCLK) disable iff (RST)
    !INTERFACE_ENABLE [*5] |-> SERIAL_DATA_LINE_OE_N)
    else $error("data line driven while disabled");
  status_off_a:
  assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == `STATUS_REG_ADDR && off_q >= 4'hA |=> RDATA == 8'h00)
    else $error("status not clear while disabled");
  flags_off_a:
  assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == `FLAG_REG_ADDR && off_q >= 4'hA |=> RDATA[7:6] == 2'b00)
    else $error("fail or busy set while disabled");
endmodule : i2c_status_flag_logic_assertions
`default_nettype wire

/* File: dv/i2c_bus_partner.sv */
// another i2c master on the bus, driving clock and data open drain
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner
(
  // pacing clock for bus phases
  input  wire logic lclk,
  // 1 means released to the pull-up
  output var  logic scl,
  output var  logic sda
);
  // idle bus: both lines released, clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // four link clocks a phase, above the three the sampler needs
  task automatic hold();
    repeat (4) @(posedge lclk);
    #1;
  endtask : hold
  // data falls while clock high
  task automatic start_c();
    sda = 1'b0;
    hold();
    scl = 1'b0;
    hold();
  endtask : start_c
  // data changes only while clock low
  task automatic bit_c(input logic b);
    sda = b;
    hold();
    scl = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask : bit_c
  // msb first, then the ack clock on behalf of the addressed slave
  task automatic byte_c(input logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--)
      bit_c(d[i]);
    bit_c(!ack);
    sda = 1'b1;
    hold();
  endtask : byte_c
  // data rises while clock high
  task automatic stop_c();
    sda = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda = 1'b1;
    hold();
  endtask : stop_c
endmodule : i2c_bus_partner
`default_nettype wire

/* File: dv/i2c_status_flag_logic_tb.sv */
// self-checking bench for the i2c status and flag logic
`timescale 1ns/1ps
`default_nettype none
`include "i2c_flag_regs.svh"
module i2c_status_flag_logic_tb;
  import i2c_flag_pkg::*;
  localparam addr_t SA = `STATUS_REG_ADDR; // status register
  localparam addr_t FA = `FLAG_REG_ADDR;   // flag register
  logic CLK = 1'b0, LCLK = 1'b0, RST = 1'b1;
  addr_t ADDR = 20'h00000;
  reg8_t WDATA = 8'h00;
  logic [7:0] RDATA;
  logic WR = 1'b0, RD = 1'b0, BITOP = 1'b0, INTERFACE_ENABLE = 1'b0;
  logic WAKEUP_ENABLE = 1'b0, COMMUNICATION_EXIT = 1'b0, WAIT_RELEASE = 1'b0;
  logic START_TRIGGER_SET = 1'b0, START_TRIGGER_CLEAR, START_GENERATED = 1'b0;
  logic ARBITRATION_LOST = 1'b0, TRANSMIT_DATA_LATCH = 1'b0, sda_p;
  addr7_t LOCAL_SLAVE_ADDRESS = 7'h2A;
  logic SERIAL_CLOCK_LINE_IN, SERIAL_DATA_LINE_OUT, SERIAL_DATA_LINE_OE_N;
  wire logic SERIAL_DATA_LINE_IN;
  int failures = 0, compares = 0;
  // wired-and of the partner and the device on the pulled-up data line
  assign SERIAL_DATA_LINE_IN = sda_p & (SERIAL_DATA_LINE_OE_N | SERIAL_DATA_LINE_OUT);
  always #20 CLK = ~CLK;
  // link clock, phase unrelated to the cpu clock
  initial
  begin
    #13;
    forever #32 LCLK = ~LCLK;
  end
  i2c_status_flag_logic i2c_status_flag_logic_inst (.*);
  i2c_bus_partner i2c_bus_partner_inst (.lclk(LCLK), .scl(SERIAL_CLOCK_LINE_IN), .sda(sda_p));
  task automatic chk(input reg8_t got, input reg8_t exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // flag crossing takes a few link clocks plus two cpu clocks
  task automatic settle();
    repeat (12) @(posedge CLK);
    #1;
  endtask : settle
  task automatic rd(input addr_t a, input reg8_t e);
    ADDR = a;
    RD = 1'b1;
    @(posedge CLK);
    #1;
    chk(RDATA, e);
    RD = 1'b0;
    @(posedge CLK);
    #1;
  endtask : rd
  task automatic wr(input addr_t a, input reg8_t d);
    ADDR = a;
    WDATA = d;
    WR = 1'b1;
    @(posedge CLK);
    #1;
    WR = 1'b0;
    @(posedge CLK);
    #1;
  endtask : wr
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge CLK);
    #1;
    s = 1'b0;
    settle();
  endtask : pulse
  task automatic lpulse(ref logic s);
    @(posedge LCLK);
    #1;
    s = 1'b1;
    @(posedge LCLK);
    #1;
    s = 1'b0;
    settle();
  endtask : lpulse
  task automatic t_flags();
    rd(FA, 8'h00);
    rd(20'h00000, 8'h00);
    wr(FA, 8'hFF);
    rd(FA, 8'h03);
    INTERFACE_ENABLE = 1'b1;
    settle();
    wr(FA, 8'h00);
    rd(FA, 8'h03);
    START_TRIGGER_SET = 1'b1;
    @(posedge CLK);
    #1;
    START_TRIGGER_SET = 1'b0;
    chk({7'h00, START_TRIGGER_CLEAR}, 8'h00);
    INTERFACE_ENABLE = 1'b0;
    settle();
    wr(FA, 8'h01);
    INTERFACE_ENABLE = 1'b1;
    settle();
    rd(FA, 8'h41);
    START_TRIGGER_SET = 1'b1;
    @(posedge CLK);
    #1;
    START_TRIGGER_SET = 1'b0;
    chk({7'h00, START_TRIGGER_CLEAR}, 8'h01);
    rd(FA, 8'hC1);
    INTERFACE_ENABLE = 1'b0;
    settle();
    rd(FA, 8'h01);
  endtask : t_flags
  task automatic t_master();
    INTERFACE_ENABLE = 1'b1;
    lpulse(START_GENERATED);
    rd(SA, 8'h88);
    lpulse(ARBITRATION_LOST);
    rd(SA, 8'h40);
    settle();
    rd(SA, 8'h00);
    lpulse(START_GENERATED);
    lpulse(ARBITRATION_LOST);
    ADDR = SA;
    pulse(BITOP);
    rd(SA, 8'h00);
    lpulse(START_GENERATED);
    pulse(WAIT_RELEASE);
    rd(SA, 8'h80);
    pulse(COMMUNICATION_EXIT);
    rd(SA, 8'h00);
    INTERFACE_ENABLE = 1'b0;
    settle();
  endtask : t_master
  task automatic t_slave();
    wr(FA, 8'h02);
    INTERFACE_ENABLE = 1'b1;
    settle();
    rd(FA, 8'h02);
    i2c_bus_partner_inst.start_c();
    settle();
    rd(SA, 8'h02);
    rd(FA, 8'h40);
    i2c_bus_partner_inst.byte_c({LOCAL_SLAVE_ADDRESS, 1'b1}, 1'b1);
    settle();
    rd(SA, 8'h1E);
    chk({7'h00, SERIAL_DATA_LINE_OE_N}, 8'h00);
    TRANSMIT_DATA_LATCH = 1'b1;
    settle();
    chk({7'h00, SERIAL_DATA_LINE_OE_N}, 8'h01);
    i2c_bus_partner_inst.bit_c(1'b1);
    settle();
    rd(SA, 8'h18);
    i2c_bus_partner_inst.stop_c();
    settle();
    rd(SA, 8'h01);
    rd(FA, 8'h00);
  endtask : t_slave
  task automatic t_ext();
    i2c_bus_partner_inst.start_c();
    settle();
    rd(SA, 8'h03);
    i2c_bus_partner_inst.byte_c(8'hF0, 1'b0);
    settle();
    rd(SA, 8'h22);
    pulse(COMMUNICATION_EXIT);
    rd(SA, 8'h00);
    i2c_bus_partner_inst.stop_c();
    settle();
    rd(SA, 8'h01);
    WAKEUP_ENABLE = 1'b1;
    settle();
    WAKEUP_ENABLE = 1'b0;
    settle();
    rd(SA, 8'h00);
    INTERFACE_ENABLE = 1'b0;
    settle();
    rd(SA, 8'h00);
  endtask : t_ext
  task automatic final_report();
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // reset spans four link clocks so both domains see it
  initial
  begin
    repeat (4) @(posedge LCLK);
    @(posedge CLK);
    #1;
    RST = 1'b0;
    settle();
    t_flags();
    t_master();
    t_slave();
    t_ext();
    final_report();
  end
  // a hang is cut off well beyond the expected run length
  initial
  begin
    #200000;
    failures++;
    final_report();
  end
endmodule : i2c_status_flag_logic_tb
bind i2c_status_flag_logic i2c_status_flag_logic_assertions i2c_status_flag_logic_assertions_inst (.*);
`default_nettype wire
